//--- spm_pkg.sv
// Constants, register map and types for the serial peripheral port.
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// R1: Transfer-complete flag sets at the end of every byte, master or slave.
// R2: Flag clears by a control write of zero or by reading the data register.
// R3: Data write during a transfer sets write-collision; software clears it.
// R4: Port works only while the enable bit, bit 5, is set.
// R5: Master-select bit 4 set: port is master and drives the serial clock.
// R6: Master-select bit clear: port is slave, serial clock is an input.
// R7: Bit 3 sets the serial clock idle level, high when set.
// R8: Bit 2 set launches data on leading edge, clear on trailing edge.
// R9: Rate code 00, 01, 10, 11 divides the core clock by 2, 4, 8, 16.
// R10: In slave mode, rate bit 0 reads back the select pin level.
// R11: Master and slave must share clock polarity and phase settings.
// R12: A data register write supplies the byte to be shifted out.
// R13: A data register read returns the byte last received.
// R14: Each transfer is one eight-bit byte, most significant bit first.
// R15: Master write starts eight serial clock periods, one sample each.
// R16: Data driven on one clock edge and sampled on the opposite one.
// R17: Slave byte ends at eighth clock with phase 1, select high with phase 0.
// R18: A colliding data write leaves the byte being shifted untouched.
package spm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_DATA = 8'hF7;
  localparam logic [7:0] IDX_CTRL = 8'hF8;
  localparam logic [7:0] IDX_STAT = 8'hF9;
  localparam logic [7:0] IDX_MASK = 8'hFA;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h04;
  localparam logic [1:0] RST_IRQ  = 2'h0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_DONE   = 7;
  localparam int unsigned BIT_WRITE_COLLISION_FLAG   = 6;
  localparam int unsigned BIT_EN     = 5;
  localparam int unsigned BIT_MASTER = 4;
  localparam int unsigned BIT_CPOL   = 3;
  localparam int unsigned BIT_CPHA   = 2;
  localparam int unsigned STAT_DONE  = 0;
  localparam int unsigned STAT_WRITE_COLLISION_FLAG  = 1;

  // ****************************************************************
  // Transfer counts
  // ****************************************************************
  localparam logic [3:0] XFER_BITS  = 4'h8;
  localparam logic [3:0] LAST_HALF  = 4'hF;
  localparam logic [2:0] HALF_DIV2  = 3'h0;
  localparam logic [2:0] HALF_DIV4  = 3'h1;
  localparam logic [2:0] HALF_DIV8  = 3'h3;
  localparam logic [2:0] HALF_DIV16 = 3'h7;

  typedef struct packed {
    logic       done;
    logic       write_collision_flag;
    logic       en;
    logic       master;
    logic       cpol;
    logic       cpha;
    logic [1:0] rate;
  } spm_ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MXFER = 2'b01,
    ST_SXFER = 2'b10,
    ST_SWAIT = 2'b11
  } spm_state_e;

endpackage : spm_pkg

//--- spm_sclk_gen.sv
// Master serial clock burst generator with selectable divide ratio.
`timescale 1ns/10ps
module spm_sclk_gen (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [1:0] rate,
  // Clock events
  output logic            act,
  output logic            lead,
  output logic            trail,
  output logic            done
);

  logic [1:0] rate_q;
  logic [2:0] div_cnt;
  logic [3:0] half_cnt;
  logic       running;
  logic [2:0] half_m1;
  logic       tick;

  // R9: divide select
  assign half_m1 = (rate_q == 2'h0) ? spm_pkg::HALF_DIV2 :
                   (rate_q == 2'h1) ? spm_pkg::HALF_DIV4 :
                   (rate_q == 2'h2) ? spm_pkg::HALF_DIV8 :
                                      spm_pkg::HALF_DIV16;
  assign tick  = running & (div_cnt == half_m1);
  assign lead  = tick & ~act;
  assign trail = tick & act;
  // R15: sixteen half periods
  assign done  = tick & (half_cnt == spm_pkg::LAST_HALF);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      running  <= 1'b0;
      act      <= 1'b0;
      div_cnt  <= 3'h0;
      half_cnt <= 4'h0;
      rate_q   <= 2'h0;
    end else if (stop) begin
      running  <= 1'b0;
      act      <= 1'b0;
      div_cnt  <= 3'h0;
      half_cnt <= 4'h0;
    end else if (start) begin
      running  <= 1'b1;
      act      <= 1'b0;
      div_cnt  <= 3'h0;
      half_cnt <= 4'h0;
      rate_q   <= rate;
    end else if (tick) begin
      div_cnt  <= 3'h0;
      act      <= ~act;
      half_cnt <= half_cnt + 4'h1;
      running  <= ~done;
    end else if (running) begin
      div_cnt  <= div_cnt + 3'h1;
    end
  end

endmodule : spm_sclk_gen

//--- spm_slave_model.sv
// Behavioural external serial slave device for master-mode transfers.
`timescale 1ns/10ps
module spm_slave_model (
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // Mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  logic [7:0] shft;
  logic       bit_o;

  initial begin
    shft  = 8'h00;
    bit_o = 1'b0;
    rx    = 8'h00;
  end

  // A released line shows the inverse of the last bit, never a held value.
  assign miso = sel_n ? ~bit_o : bit_o;

  always @(negedge sel_n) begin
    shft = tx;
    if (!cpha) begin
      bit_o <= #1 shft[7];
      shft = {shft[6:0], 1'b0};
    end
  end

  always @(sclk) begin
    if (!sel_n && ((sclk != cpol) ^ cpha)) begin
      rx = {rx[6:0], mosi};
    end else if (!sel_n) begin
      bit_o <= #1 shft[7];
      shft = {shft[6:0], 1'b0};
    end
  end
endmodule : spm_slave_model

//--- spm_spi_port.sv
// Byte-wide serial peripheral port, master or slave, with an APB slave.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module spm_spi_port (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Serial pins
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  input  wire logic        ss_n
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [7:0]  idx);
    reg_hit = (a == {2'h0, idx, 2'h0});
  endfunction : reg_hit

  spm_pkg::spm_ctrl_s  ctl;
  spm_pkg::spm_state_e state;
  spm_pkg::spm_state_e next_state;
  logic [7:0] rx_data;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [3:0] cnt;
  logic [1:0] stat;
  logic [1:0] mask;
  logic       sclk_q;

  wire acc    = psel & penable & pready;
  wire ans    = psel & penable & ~pready;
  wire hit_d  = reg_hit(paddr, spm_pkg::IDX_DATA);
  wire hit_c  = reg_hit(paddr, spm_pkg::IDX_CTRL);
  wire hit_s  = reg_hit(paddr, spm_pkg::IDX_STAT);
  wire hit_m  = reg_hit(paddr, spm_pkg::IDX_MASK);
  wire mapped = hit_d | hit_c | hit_s | hit_m;
  wire wr_dat = acc & pwrite & hit_d;
  wire wr_ctl = acc & pwrite & hit_c;
  wire wr_msk = acc & pwrite & hit_m;
  wire rd_dat = acc & ~pwrite & hit_d;
  wire rd_sts = acc & ~pwrite & hit_s;

  // R10: select pin level on rate bit 0 in slave mode
  wire rate_lo = ctl.master ? ctl.rate[0] : ss_n;
  wire [7:0] ctl_rd = {ctl.done, ctl.write_collision_flag, ctl.en, ctl.master,
                       ctl.cpol, ctl.cpha, ctl.rate[1], rate_lo};
  wire [7:0] rd_mux = hit_d ? rx_data :
                      hit_c ? ctl_rd :
                      hit_s ? {6'h00, stat} :
                      hit_m ? {6'h00, mask} : 8'h00;

  // ****************************************************************
  // Serial clock events
  // ****************************************************************
  wire busy     = (state != spm_pkg::ST_IDLE);
  // R5: master mode
  wire m_mode   = ctl.en & ctl.master;
  // R6: slave mode
  wire s_mode   = ctl.en & ~ctl.master;
  wire s_sel    = s_mode & ~ss_n;
  // R15: master write starts a burst
  wire m_start  = wr_dat & ~busy & m_mode;
  wire g_act;
  wire g_lead;
  wire g_trail;
  wire g_done;

  spm_sclk_gen spm_sclk_gen_inst (
    .mclk  (mclk),
    .rst   (rst),
    .start (m_start),
    .stop  (~m_mode),
    .rate  (ctl.rate),
    .act   (g_act),
    .lead  (g_lead),
    .trail (g_trail),
    .done  (g_done)
  );

  // R11: both ends read the clock with the same polarity
  wire lvl    = sclk_in ^ ctl.cpol;
  wire lvl_q  = sclk_q ^ ctl.cpol;
  wire s_lead = s_sel & lvl & ~lvl_q;
  wire s_trl  = s_sel & ~lvl & lvl_q;
  wire lead   = m_mode ? g_lead : s_lead;
  wire trail  = m_mode ? g_trail : s_trl;
  // R8: phase picks the launching edge
  // R16: sample on the opposite edge
  wire samp_ev = ctl.cpha ? trail : lead;
  wire lnch_ev = ctl.cpha ? lead : trail;
  wire din     = m_mode ? miso_in : mosi_in;
  wire last_s  = samp_ev & (cnt == spm_pkg::XFER_BITS - 4'h1);

  // ****************************************************************
  // Transfer sequencing
  // ****************************************************************
  logic xfer_done;

  always_comb begin
    next_state = state;
    xfer_done  = 1'b0;
    case (state)
      spm_pkg::ST_IDLE: begin
        if (m_start) begin
          next_state = spm_pkg::ST_MXFER;
        end else if (s_sel && samp_ev) begin
          next_state = spm_pkg::ST_SXFER;
        end
      end
      spm_pkg::ST_MXFER: begin
        // R1: master byte ends with the burst
        if (g_done) begin
          next_state = spm_pkg::ST_IDLE;
          xfer_done  = 1'b1;
        end
      end
      spm_pkg::ST_SXFER: begin
        // R17: slave end of byte by phase
        if (ss_n) begin
          next_state = spm_pkg::ST_IDLE;
        end else if (last_s && ctl.cpha) begin
          next_state = spm_pkg::ST_IDLE;
          xfer_done  = 1'b1;
        end else if (last_s) begin
          next_state = spm_pkg::ST_SWAIT;
        end
      end
      spm_pkg::ST_SWAIT: begin
        if (ss_n) begin
          next_state = spm_pkg::ST_IDLE;
          xfer_done  = 1'b1;
        end
      end
      default: begin
        next_state = spm_pkg::ST_IDLE;
      end
    endcase
    // R4: disabled or mode changed stops the port
    if (!ctl.en || (ctl.master != (state == spm_pkg::ST_MXFER)
                    && busy)) begin
      next_state = spm_pkg::ST_IDLE;
      xfer_done  = 1'b0;
    end
  end

  // R3: collision on a write while busy
  wire write_collision_flag_ev = wr_dat & busy;
  // R18: load only when idle
  wire tx_load = wr_dat & ~busy;
  // R14: shift out most significant bit first
  wire tx_shft = lnch_ev & (cnt != 4'h0) & busy;
  wire [7:0] rx_next = {rx_sh[6:0], din};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= spm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
    end else if (next_state == spm_pkg::ST_IDLE) begin
      cnt <= 4'h0;
    end else if (samp_ev) begin
      cnt <= cnt + 4'h1;
    end
  end

  // R12: written byte feeds the shifter
  wire [7:0] next_tx = tx_load ? pwdata[7:0] :
                       tx_shft ? {tx_sh[6:0], 1'b0} : tx_sh;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_sh <= spm_pkg::RST_DATA;
    end else begin
      tx_sh <= next_tx;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_sh <= 8'h00;
    end else if (samp_ev && (busy || next_state != spm_pkg::ST_IDLE)) begin
      rx_sh <= rx_next;
    end
  end

  // R13: received byte latched only at completion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_data <= spm_pkg::RST_DATA;
    end else if (xfer_done) begin
      rx_data <= (samp_ev && busy) ? rx_next : rx_sh;
    end
  end

  // ****************************************************************
  // Control register and interrupt
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl <= spm_pkg::RST_CTRL;
    end else begin
      if (wr_ctl) begin
        ctl.en     <= pwdata[spm_pkg::BIT_EN];
        ctl.master <= pwdata[spm_pkg::BIT_MASTER];
        // R7: idle level select
        ctl.cpol   <= pwdata[spm_pkg::BIT_CPOL];
        ctl.cpha   <= pwdata[spm_pkg::BIT_CPHA];
        ctl.rate   <= pwdata[1:0];
      end
      // R2: cleared by a zero write or a data read, set wins
      ctl.done <= xfer_done | (ctl.done & ~rd_dat &
                  ~(wr_ctl & ~pwdata[spm_pkg::BIT_DONE]));
      // R3: sticky until software clears it
      ctl.write_collision_flag <= write_collision_flag_ev | (ctl.write_collision_flag &
                  ~(wr_ctl & ~pwdata[spm_pkg::BIT_WRITE_COLLISION_FLAG]));
    end
  end

  wire [1:0] ev = {write_collision_flag_ev, xfer_done};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat <= spm_pkg::RST_IRQ;
      mask <= spm_pkg::RST_IRQ;
      irq  <= 1'b0;
    end else begin
      stat <= ev | (stat & ~{2{rd_sts}});
      mask <= wr_msk ? pwdata[1:0] : mask;
      irq  <= |(stat & mask);
    end
  end

  // ****************************************************************
  // Bus answer and pin drivers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= ans;
      prdata  <= (ans && !pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
      pslverr <= ans & ~mapped;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q    <= 1'b0;
      sclk_out  <= 1'b0;
      sclk_oe_n <= 1'b1;
      mosi_out  <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_out  <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      sclk_q    <= sclk_in;
      // R7: idle level plus burst activity
      // R16: pin edge with sample
      // The pin flips at the edge where the internal sample is taken.
      sclk_out  <= ctl.cpol ^ g_act ^ (g_lead | g_trail);
      sclk_oe_n <= ~m_mode;
      mosi_out  <= next_tx[7];
      mosi_oe_n <= ~m_mode;
      miso_out  <= next_tx[7];
      miso_oe_n <= ~s_sel;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [3:0] m_trails;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      m_trails <= 4'h0;
    end else if (m_start) begin
      m_trails <= 4'h0;
    end else if (g_trail) begin
      m_trails <= m_trails + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_done_set: assert property (xfer_done |=> ctl.done) // R1
    else $error("done flag not set after a transfer");
  a_done_rdclr: assert property ((rd_dat && !xfer_done) |=> !ctl.done) // R2
    else $error("data read did not clear done flag");
  a_write_collision_flag_set: assert property (write_collision_flag_ev |=> ctl.write_collision_flag && $stable(tx_sh) ||
                               ctl.write_collision_flag && tx_shft) // R3
    else $error("collision flag not set");
  a_write_collision_flag_hold: assert property ((ctl.write_collision_flag && !wr_ctl) |=> ctl.write_collision_flag) // R3
    else $error("collision flag dropped by itself");
  a_off_quiet: assert property ((!ctl.en)[*2] |->
                 sclk_oe_n && mosi_oe_n && miso_oe_n) // R4
    else $error("pins driven while disabled");
  a_master_drv: assert property ((ctl.en && ctl.master)[*2] |->
                  !sclk_oe_n && !mosi_oe_n && miso_oe_n) // R5
    else $error("master does not drive clock");
  a_slave_in: assert property ((ctl.en && !ctl.master)[*2] |->
                sclk_oe_n && mosi_oe_n) // R6
    else $error("slave drives clock or mosi");
  a_idle_level: assert property ((m_mode && !busy &&
                  $stable(ctl.cpol))[*2] |-> sclk_out == ctl.cpol) // R7
    else $error("serial clock not at idle level");
  a_rate_rd: assert property ((ans && !pwrite && hit_c && !ctl.master)
                |=> prdata[0] == $past(ss_n)) // R10
    else $error("rate bit 0 does not show select pin");
  a_eight_clk: assert property ((state == spm_pkg::ST_MXFER && g_done)
                 |-> m_trails == 4'h7) // R15
    else $error("master burst is not eight clocks");
  a_coll_keep: assert property ((write_collision_flag_ev && !tx_shft) |=>
                 tx_sh == $past(tx_sh)) // R18
    else $error("colliding write changed the shifter");

  c_master_done: cover property (state == spm_pkg::ST_MXFER && xfer_done);
  c_slave_done: cover property (state != spm_pkg::ST_MXFER && xfer_done);
  c_collision: cover property (write_collision_flag_ev);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule : spm_spi_port

//--- spm_spi_port_tb.sv
// Self-checking bench for the serial peripheral port.
`timescale 1ns/10ps
module spm_spi_port_tb;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out;
  logic        miso_oe_n, tb_sclk, tb_mosi, ss_n, sel_n, prev_sclk;
  logic        m_cpol, m_cpha, mdl_miso;
  logic [7:0]  m_tx, m_rx;
  int          miscompares, num_checks, ntog, gap, lastgap;
  wire logic   sclk_w = sclk_oe_n ? tb_sclk : sclk_out;
  wire logic   mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
  wire logic   miso_w = miso_oe_n ? mdl_miso : miso_out;

  spm_spi_port spm_spi_port_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .ss_n(ss_n));

  spm_slave_model spm_slave_model_inst (
    .sclk(sclk_w), .mosi(mosi_w), .sel_n(sel_n), .miso(mdl_miso),
    .cpol(m_cpol), .cpha(m_cpha), .tx(m_tx), .rx(m_rx));

  always #4 mclk = ~mclk;

  // Counts serial clock toggles and the cycles between the last two.
  always @(posedge mclk) begin
    prev_sclk <= sclk_out;
    if (sclk_out !== prev_sclk) begin
      ntog    <= ntog + 1;
      lastgap <= gap;
      gap     <= 1;
    end else begin
      gap <= gap + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic tmo(input string what);
    miscompares++;
    $display("mismatch %s expected answer seen timeout", what);
    tally_and_finish;
  endtask : tmo

  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, ix, 2'b00};
    pwdata <= {24'h000000, v};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = pslverr ? 32'hFFFFFFFF : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) tmo("pready");
  endtask : apb

  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask : settle

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (n >= lim) tmo("irq");
  endtask : wait_irq

  task automatic t_reset;
    settle;
    chk("sclk_oe_n", sclk_oe_n, 1'b1);
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("ctrl", rdat, 32'h05);
    apb(0, spm_pkg::IDX_DATA, 8'h00);
    chk("data", rdat, 32'h00);
    apb(0, 8'h00, 8'h00);
    chk("unmapped", rdat, 32'hFFFFFFFF);
    apb(1, spm_pkg::IDX_MASK, 8'h01);
    apb(0, spm_pkg::IDX_MASK, 8'h00);
    chk("mask", rdat, 32'h01);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_master(input logic [1:0] r, input logic [7:0] d, s);
    @(posedge mclk);
    m_cpol <= r[1];
    m_cpha <= r[0];
    m_tx   <= s;
    apb(1, spm_pkg::IDX_CTRL, {4'b0011, r[1], r[0], r});
    repeat (3) @(posedge mclk);
    ntog  <= 0;
    sel_n <= 1'b0;
    settle;
    chk("sclk_oe_n", sclk_oe_n, 1'b0);
    chk("idle", sclk_out, r[1]);
    apb(1, spm_pkg::IDX_DATA, d);
    wait_irq(400);
    settle;
    chk("toggles", ntog, 16);
    chk("half", lastgap, 32'(1) << r);
    chk("end idle", sclk_out, r[1]);
    chk("mosi byte", m_rx, d);
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("done", rdat[7], 1'b1);
    apb(0, spm_pkg::IDX_DATA, 8'h00);
    chk("miso byte", rdat, s);
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("done clr", rdat[7], 1'b0);
    apb(0, spm_pkg::IDX_STAT, 8'h00);
    chk("status", rdat, 32'h01);
    settle;
    chk("irq clr", irq, 1'b0);
    @(posedge mclk);
    sel_n <= 1'b1;
    $display("test master rate %0d finished", r);
  endtask : t_master

  task automatic t_write_collision_flag;
    @(posedge mclk);
    m_cpol <= 1'b0;
    m_cpha <= 1'b0;
    apb(1, spm_pkg::IDX_MASK, 8'h02);
    apb(1, spm_pkg::IDX_CTRL, 8'h33);
    @(posedge mclk);
    sel_n <= 1'b0;
    apb(1, spm_pkg::IDX_DATA, 8'h3C);
    apb(1, spm_pkg::IDX_DATA, 8'hC3);
    wait_irq(20);
    apb(1, spm_pkg::IDX_MASK, 8'h01);
    settle;
    chk("irq masked", irq, 1'b0);
    wait_irq(400);
    chk("kept byte", m_rx, 8'h3C);
    apb(0, spm_pkg::IDX_STAT, 8'h00);
    chk("status", rdat, 32'h03);
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("write_collision_flag", rdat[7:6], 2'b11);
    apb(1, spm_pkg::IDX_CTRL, 8'h33);
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("flags clr", rdat[7:6], 2'b00);
    sel_n <= 1'b1;
    $display("test collision finished");
  endtask : t_write_collision_flag

  task automatic t_off;
    apb(1, spm_pkg::IDX_CTRL, 8'h13);
    repeat (3) @(posedge mclk);
    ntog <= 0;
    apb(1, spm_pkg::IDX_DATA, 8'h5A);
    repeat (200) @(posedge mclk);
    chk("no clocks", ntog, 0);
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("no done", rdat[7], 1'b0);
    $display("test disabled finished");
  endtask : t_off

  task automatic t_slave(input logic cph, input logic [7:0] md, sd);
    logic [7:0] got;
    tb_sclk <= cph;
    apb(1, spm_pkg::IDX_CTRL, {4'b0010, cph, cph, 2'b00});
    apb(1, spm_pkg::IDX_DATA, sd);
    settle;
    chk("sclk_oe_n", sclk_oe_n, 1'b1);
    @(posedge mclk);
    ss_n <= 1'b0;
    apb(0, spm_pkg::IDX_CTRL, 8'h00);
    chk("ss level", rdat[0], 1'b0);
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      if (!cph) tb_mosi <= md[i];
      repeat (4) @(posedge mclk);
      if (!cph) got[i] = miso_w;
      tb_sclk <= ~cph;
      if (cph) tb_mosi <= md[i];
      repeat (4) @(posedge mclk);
      if (cph) got[i] = miso_w;
      tb_sclk <= cph;
    end
    if (!cph) begin
      repeat (8) @(posedge mclk);
      chk("early done", irq, 1'b0);
      ss_n <= 1'b1;
    end
    wait_irq(20);
    chk("miso byte", got, sd);
    apb(0, spm_pkg::IDX_DATA, 8'h00);
    chk("mosi byte", rdat, md);
    apb(0, spm_pkg::IDX_STAT, 8'h00);
    chk("status", rdat, 32'h01);
    ss_n <= 1'b1;
    $display("test slave phase %0d finished", cph);
  endtask : t_slave

  initial begin
    mclk        = 1'b0;
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    tb_sclk     = 1'b0;
    tb_mosi     = 1'b0;
    ss_n        = 1'b1;
    sel_n       = 1'b1;
    m_cpol      = 1'b0;
    m_cpha      = 1'b0;
    m_tx        = 8'h00;
    miscompares = 0;
    num_checks  = 0;
    ntog        = 0;
    gap         = 0;
    lastgap     = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    for (int r = 0; r < 4; r++) begin
      t_master(2'(r), 8'hB1 + 8'(r), 8'h4E - 8'(r));
    end
    t_write_collision_flag;
    t_off;
    t_slave(1'b1, 8'hA7, 8'h5C);
    t_slave(1'b0, 8'h1E, 8'hE2);
    tally_and_finish;
  end
endmodule : spm_spi_port_tb
